/* File: rtl/srw_pkg.sv */
// Package with constants and types for the supply reset watchdog.
package srw_pkg;

  // Rate of the block clock, which stands in for the internal oscillator.
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;

  // Reset stretch after power-up, supply recovery or watchdog bite.
  localparam int unsigned STRETCH_MS      = 250;
  localparam int unsigned STRETCH_CYC     = CYC_PER_MS * STRETCH_MS;

  // The three preset watchdog intervals.
  localparam int unsigned WD_LONG_MS      = 1400;
  localparam int unsigned WD_MID_MS       = 600;
  localparam int unsigned WD_SHORT_MS     = 200;
  localparam int unsigned WD_LONG_CYC     = CYC_PER_MS * WD_LONG_MS;
  localparam int unsigned WD_MID_CYC      = CYC_PER_MS * WD_MID_MS;
  localparam int unsigned WD_SHORT_CYC    = CYC_PER_MS * WD_SHORT_MS;

  // Width of the shared time counter.
  localparam int unsigned CNT_W           = 32;

  // Watchdog interval selection codes.
  typedef enum logic [1:0] {
    SRW_WD_LONG  = 2'h0,
    SRW_WD_MID   = 2'h1,
    SRW_WD_SHORT = 2'h2,
    SRW_WD_OFF   = 2'h3
  } srw_wd_sel_type;

  // Control register contents.
  typedef struct packed {
    logic           protect_lock_enable;
    srw_wd_sel_type wd_sel;
  } srw_ctrl_type;

  // Value the control register takes on its one-time initialisation.
  localparam srw_ctrl_type CTRL_INIT = '{protect_lock_enable: 1'b0, wd_sel: SRW_WD_LONG};

  // Supervisor states, Gray coded along power-up, hold, run.
  typedef enum logic [1:0] {
    SRW_ST_POWERUP = 2'h0,
    SRW_ST_HOLD    = 2'h1,
    SRW_ST_RUN     = 2'h3
  } srw_state_type;

endpackage : srw_pkg

/* File: rtl/srw_supply_reset_watchdog.sv */
// Supply supervisor: open-drain reset, power-up stretch and 2-wire watchdog.
`timescale 1ns/10ps

// Summary of operation
// - Reset asserted open drain while supply low.
// - Hold reset 250ms after supply recovers.
// - Power-up asserts reset for 250ms.
// - Enabled watchdog resets when no start condition comes in time.
// - SDA falling while SCL high restarts watchdog.
// - Timeout picked from three preset intervals.
// - Selected interval survives power cycling.
// - Protect pin plus lock bit blocks writes.
module srw_supply_reset_watchdog #(
  parameter bit          ACTIVE_HIGH  = 1'b0,
  parameter int unsigned STRETCH_CYCS = srw_pkg::STRETCH_CYC,
  parameter int unsigned WD_LONG      = srw_pkg::WD_LONG_CYC,
  parameter int unsigned WD_MID       = srw_pkg::WD_MID_CYC,
  parameter int unsigned WD_SHORT     = srw_pkg::WD_SHORT_CYC
) (
  // Oscillator clock and power-up reset.
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Link clock and the reset of the retained control store.
  input  wire logic                 link_clk_i,
  input  wire logic                 link_rst_i,
  // Asynchronous supply and bus pins.
  input  wire logic                 supply_low_i,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  input  wire logic                 wp_i,
  // Control register write port, link domain.
  input  wire logic                 ctrl_wr_i,
  input  wire srw_pkg::srw_ctrl_type ctrl_wr_data_i,
  output logic                      ctrl_wr_refused_o,
  // Reset pin as output value and drive enable.
  output logic                      reset_o,
  output logic                      reset_oe_o,
  // Control setting in use by the watchdog.
  output srw_pkg::srw_ctrl_type     ctrl_o
);
  import srw_pkg::*;

  // Timeout in cycles for a selection code; off never times out.
  function automatic logic [CNT_W-1:0] wd_limit(input srw_wd_sel_type sel);
    logic [CNT_W-1:0] lim;
    lim = '1;
    unique case (sel)
      SRW_WD_LONG:  lim = WD_LONG[CNT_W-1:0];
      SRW_WD_MID:   lim = WD_MID[CNT_W-1:0];
      SRW_WD_SHORT: lim = WD_SHORT[CNT_W-1:0];
      SRW_WD_OFF:   lim = '1;
    endcase
    return lim;
  endfunction : wd_limit

  // ---------------- Link domain ----------------
  srw_ctrl_type ctrl_store;     // Retained control register.
  srw_ctrl_type ctrl_xfer;      // Snapshot held stable for the crossing.
  logic         wp_meta;        // Protect pin, first sync stage.
  logic         wp_sync;        // Protect pin, synchronised.
  logic         req_meta;       // Request toggle, first sync stage.
  logic         req_sync;       // Request toggle, synchronised.
  logic         req_seen;       // Last request toggle answered.
  logic         ack_tgl;        // Answer toggle towards the clock domain.
  logic         req_tgl;        // Request toggle, driven from the clock domain.

  // Two flops on the protect pin before it gates anything.
  always_ff @(posedge link_clk_i) begin
    wp_meta <= wp_i;
    wp_sync <= wp_meta;
  end

  // Control store. Only link_rst_i clears it, so a power-up reset on
  // rst_i leaves the chosen interval untouched, as nonvolatile storage would.
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      ctrl_store        <= CTRL_INIT;
      ctrl_wr_refused_o <= 1'b0;
    end else begin
      ctrl_wr_refused_o <= 1'b0;
      if (ctrl_wr_i) begin
        if (wp_sync && ctrl_store.protect_lock_enable) begin
          ctrl_wr_refused_o <= 1'b1;
        end else begin
          ctrl_store <= ctrl_wr_data_i;
        end
      end
    end
  end

  // Answer side of the handshake: on each new request, freeze a snapshot
  // and toggle the answer. The snapshot then stays put until the next
  // request, which cannot come before the answer has been seen.
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      req_meta  <= 1'b0;
      req_sync  <= 1'b0;
      req_seen  <= 1'b0;
      ack_tgl   <= 1'b0;
      ctrl_xfer <= CTRL_INIT;
    end else begin
      req_meta <= req_tgl;
      req_sync <= req_meta;
      if (req_sync != req_seen) begin
        req_seen  <= req_sync;
        ctrl_xfer <= ctrl_store;
        ack_tgl   <= ~ack_tgl;
      end
    end
  end

  // ---------------- Clock domain ----------------
  logic             ack_meta;   // Answer toggle, first sync stage.
  logic             ack_sync;   // Answer toggle, synchronised.
  logic             ack_seen;   // Last answer consumed.
  logic             low_meta;   // Supply-low, first sync stage.
  logic             low_sync;   // Supply-low, synchronised.
  logic             scl_meta;   // SCL, first sync stage.
  logic             scl_sync;   // SCL, synchronised.
  logic             sda_meta;   // SDA, first sync stage.
  logic             sda_sync;   // SDA, synchronised.
  logic             sda_prev;   // SDA one cycle earlier.
  logic             kick;       // Watchdog restart event.
  srw_state_type    state;      // Supervisor state.
  logic [CNT_W-1:0] cnt;        // Stretch or watchdog time.
  logic             bite;       // Watchdog has expired this cycle.

  // Two flops on every pin before logic reads it.
  always_ff @(posedge clk_i) begin
    low_meta <= supply_low_i;
    low_sync <= low_meta;
    scl_meta <= scl_i;
    scl_sync <= scl_meta;
    sda_meta <= sda_i;
    sda_sync <= sda_meta;
  end

  // Start-condition detector. Only the falling edge counts; SDA parked
  // high or low does not feed the watchdog.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_prev <= 1'b1;
      kick     <= 1'b0;
    end else begin
      sda_prev <= sda_sync;
      kick     <= sda_prev && !sda_sync && scl_sync;
    end
  end

  // Request side of the handshake: polls the control store continuously,
  // so a fresh copy arrives after every power-up reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
      ack_seen <= 1'b0;
      req_tgl  <= 1'b0;
      ctrl_o   <= CTRL_INIT;
    end else begin
      ack_meta <= ack_tgl;
      ack_sync <= ack_meta;
      if (ack_sync != ack_seen) begin
        ack_seen <= ack_sync;
        ctrl_o   <= ctrl_xfer;
      end
      // Ask again only once the last answer has arrived.
      if (ack_sync == req_tgl && ack_seen == ack_sync) begin
        req_tgl <= ~req_tgl;
      end
    end
  end

  // Watchdog expiry; the off code can never be reached by the counter.
  assign bite = (state == SRW_ST_RUN) && (ctrl_o.wd_sel != SRW_WD_OFF) &&
                (cnt >= wd_limit(ctrl_o.wd_sel) - 1'b1);

  // Supervisor. Power-up and supply-low both start the stretch; the run
  // state counts time since the last watchdog restart.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= SRW_ST_POWERUP;
      cnt   <= '0;
    end else begin
      unique case (state)
        SRW_ST_POWERUP: begin
          cnt   <= '0;
          state <= SRW_ST_HOLD;
        end
        SRW_ST_HOLD: begin
          if (low_sync) begin
            cnt <= '0;
          end else if (cnt >= STRETCH_CYCS[CNT_W-1:0] - 1'b1) begin
            cnt   <= '0;
            state <= SRW_ST_RUN;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        SRW_ST_RUN: begin
          if (low_sync || bite) begin
            cnt   <= '0;
            state <= SRW_ST_HOLD;
          end else if (kick || ctrl_o.wd_sel == SRW_WD_OFF) begin
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        default: begin
          cnt   <= '0;
          state <= SRW_ST_HOLD;
        end
      endcase
    end
  end

  // Open-drain pad: the active-low part pulls down while in reset, the
  // active-high part pulls down while out of reset; the pull-up does the rest.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_o    <= 1'b0;
      reset_oe_o <= !ACTIVE_HIGH;
    end else begin
      reset_o    <= 1'b0;
      reset_oe_o <= (state != SRW_ST_RUN || low_sync) ? !ACTIVE_HIGH
                                                      : ACTIVE_HIGH;
    end
  end

endmodule : srw_supply_reset_watchdog

/* File: verif/srw_assertions.sv */
// Port checker for the supply reset watchdog.
`timescale 1ns/10ps
module srw_assertions
  import srw_pkg::*;
#(
  parameter bit          ACTIVE_HIGH  = 1'b0,
  parameter int unsigned STRETCH_CYCS = 50,
  parameter int unsigned WD_LONG      = 400,
  parameter int unsigned WD_MID       = 200,
  parameter int unsigned WD_SHORT     = 100
) (
  // Clocks and resets.
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         link_clk_i,
  input wire logic         link_rst_i,
  // Pins, write port and outputs.
  input wire logic         supply_low_i,
  input wire logic         scl_i,
  input wire logic         sda_i,
  input wire logic         wp_i,
  input wire logic         ctrl_wr_i,
  input wire logic         ctrl_wr_refused_o,
  input wire logic         reset_o,
  input wire logic         reset_oe_o,
  input wire srw_ctrl_type ctrl_o
);
  logic        sda_q;   // SDA one cycle back.
  int unsigned hi_len;  // Cycles of reset held on good supply.
  int unsigned quiet;   // Cycles running with no kick.
  int unsigned lowc;    // Cycles since supply was last low.
  int unsigned lim;     // Interval now selected.
  // The pin is seen here before the design syncs it, so bounds carry slack.
  wire kick = scl_i & sda_q & ~sda_i;
  // Reset as the system sees it; the active-high part pulls down the other way.
  wire in_rst = reset_oe_o ^ ACTIVE_HIGH;
  always_comb begin
    case (ctrl_o.wd_sel)
      SRW_WD_LONG: lim = WD_LONG;
      SRW_WD_MID:  lim = WD_MID;
      default:     lim = WD_SHORT;
    endcase
  end
  // Run-length counters kept beside the design.
  always_ff @(posedge clk_i) begin
    sda_q  <= sda_i;
    hi_len <= (rst_i | supply_low_i | ~in_rst) ? 0 : hi_len + 1;
    quiet  <= (rst_i | in_rst | kick | ctrl_o.wd_sel == SRW_WD_OFF) ? 0 : quiet + 1;
    lowc   <= (rst_i | supply_low_i) ? 0 : lowc + 32'(lowc < 99);
  end
  drain_only_a:
    assert property (@(posedge clk_i) disable iff (rst_i) !reset_o) else $error("pad high");
  low_asserts_a:
    assert property (@(posedge clk_i) disable iff (rst_i) supply_low_i |-> ##[1:5] in_rst)
    else $error("no reset on low supply");
  stretch_len_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(in_rst) |-> hi_len >= STRETCH_CYCS) else $error("reset pulse too short");
  wd_bound_a:
    assert property (@(posedge clk_i) disable iff (rst_i) quiet <= lim + 8)
    else $error("watchdog late");
  early_bite_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(in_rst) && lowc > 8 |-> quiet + 8 >= lim) else $error("watchdog early");
  off_quiet_a:
    assert property (@(posedge clk_i) disable iff (rst_i) $rose(in_rst) && lowc > 8
      |-> $past(ctrl_o.wd_sel) != SRW_WD_OFF) else $error("bite while off");
  refuse_cause_a:
    assert property (@(posedge link_clk_i) disable iff (link_rst_i) ctrl_wr_refused_o
      |-> $past(ctrl_wr_i) || $past(ctrl_wr_i, 2)) else $error("refusal without write");
  refuse_wp_a:
    assert property (@(posedge link_clk_i) disable iff (link_rst_i)
      ctrl_wr_refused_o |-> $past(wp_i, 3)) else $error("refusal with pin low");
  bite_c: cover property (@(posedge clk_i) $rose(in_rst) && lowc > 8);
  kick_c: cover property (@(posedge clk_i) kick);
  refuse_c: cover property (@(posedge link_clk_i) ctrl_wr_refused_o);
endmodule : srw_assertions
bind srw_supply_reset_watchdog srw_assertions #(.ACTIVE_HIGH(ACTIVE_HIGH),
  .STRETCH_CYCS(STRETCH_CYCS),
  .WD_LONG(WD_LONG), .WD_MID(WD_MID), .WD_SHORT(WD_SHORT)) srw_assertions_i (.clk_i,
  .rst_i, .link_clk_i, .link_rst_i, .supply_low_i, .scl_i, .sda_i, .wp_i, .ctrl_wr_i,
  .ctrl_wr_refused_o, .reset_o, .reset_oe_o, .ctrl_o);

/* File: verif/srw_mcu_model.sv */
// Bus master model that kicks the watchdog.
`timescale 1ns/10ps
module srw_mcu_model (
  // Clock and commands.
  input  wire logic clk_i,
  input  wire logic kick_i,
  input  wire logic bad_i,
  // Bus lines, high through pull-ups when released.
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // SDA falls with SCL high; bad_i lowers SCL first so the edge does not count.
  always @(posedge clk_i) begin
    if (kick_i) begin
      scl_o <= ~bad_i;
      repeat (4) @(posedge clk_i);
      sda_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      sda_o <= 1'b1;
      scl_o <= 1'b1;
    end
  end
endmodule : srw_mcu_model

/* File: verif/testbench.sv */
// Self-checking bench for the supply reset watchdog.
`timescale 1ns/10ps
module testbench;
  import srw_pkg::*;
  localparam int ST = 50;
  localparam int LIM [3] = '{400, 200, 100};
  localparam srw_ctrl_type LK = '{1'b1, SRW_WD_OFF};
  localparam srw_ctrl_type OFF = '{1'b0, SRW_WD_OFF};
  logic clk_i = 0, rst_i = 1, link_clk_i = 0, link_rst_i = 1, supply_low_i = 0;
  logic wp_i = 0, ctrl_wr_i = 0, kick = 0, bad = 0;
  logic scl, sda, ctrl_wr_refused_o, reset_o, reset_oe_o;
  logic hi_reset, hi_oe;  // Pad of the active-high variant.
  srw_ctrl_type ctrl_wr_data_i = CTRL_INIT;
  srw_ctrl_type ctrl_o;
  int errors = 0, checked = 0, cyc = 0;
  always #2.5 clk_i = ~clk_i;
  initial #13 forever #40 link_clk_i = ~link_clk_i;
  srw_supply_reset_watchdog #(.STRETCH_CYCS(ST), .WD_LONG(LIM[0]), .WD_MID(LIM[1]),
    .WD_SHORT(LIM[2])) srw_supply_reset_watchdog_i (.clk_i, .rst_i, .link_clk_i,
    .link_rst_i, .supply_low_i, .scl_i(scl), .sda_i(sda), .wp_i, .ctrl_wr_i,
    .ctrl_wr_data_i, .ctrl_wr_refused_o, .reset_o, .reset_oe_o, .ctrl_o);
  // Active-high variant on the same stimulus; only its pad is judged.
  srw_supply_reset_watchdog #(.ACTIVE_HIGH(1'b1), .STRETCH_CYCS(ST), .WD_LONG(LIM[0]),
    .WD_MID(LIM[1]), .WD_SHORT(LIM[2])) srw_supply_reset_watchdog_hi_i (.clk_i, .rst_i,
    .link_clk_i, .link_rst_i, .supply_low_i, .scl_i(scl), .sda_i(sda), .wp_i, .ctrl_wr_i,
    .ctrl_wr_data_i, .ctrl_wr_refused_o(), .reset_o(hi_reset), .reset_oe_o(hi_oe), .ctrl_o());
  srw_mcu_model srw_mcu_model_i (.clk_i, .kick_i(kick), .bad_i(bad), .scl_o(scl),
    .sda_o(sda));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  // Bounded wait for the reset pin enable to reach v.
  task automatic wait_oe(input logic v, input int lim, output int n);
    for (n = 0; reset_oe_o !== v && n < lim; n++) step(1);
    check(n < lim, 1);
    // Both pads stay open drain; the active-high part drives the opposite enable.
    check({hi_oe, hi_reset, reset_o}, {!v, 2'b00});
  endtask : wait_oe
  // One link write; the refusal pulse may stand in either following cycle.
  task automatic wr(input srw_ctrl_type d, input logic refused);
    logic r;
    @(posedge link_clk_i) #1 ctrl_wr_i = 1;
    ctrl_wr_data_i = d;
    @(posedge link_clk_i) #1 ctrl_wr_i = 0;
    r = ctrl_wr_refused_o;
    @(posedge link_clk_i) #1 r |= ctrl_wr_refused_o;
    check(r, refused);
    step(300);
  endtask : wr
  task automatic t_power;
    int n;
    rst_i = 1;
    step(20);
    rst_i = 0;
    wait_oe(0, 200, n);
    check(n >= ST && n <= ST + 8, 1);
    $display("power-up test done");
  endtask : t_power
  task automatic t_supply;
    int n;
    supply_low_i = 1;
    step(10);
    check(reset_oe_o, 1);
    supply_low_i = 0;
    step(20);
    // A short dip in the middle of the stretch must restart it from zero.
    supply_low_i = 1;
    step(2);
    supply_low_i = 0;
    wait_oe(0, 200, n);
    check(n >= ST && n <= ST + 8, 1);
    $display("supply test done");
  endtask : t_supply
  // Each interval timed from the end of one bite to the next, then kicks.
  task automatic t_wdog;
    int n;
    for (int s = 0; s < 3; s++) begin
      wr(OFF, 0);
      wr('{1'b0, srw_wd_sel_type'(s)}, 0);
      wait_oe(1, 1000, n);
      wait_oe(0, 200, n);
      wait_oe(1, 1000, n);
      check(n >= LIM[s] - 2 && n <= LIM[s] + 4, 1);
    end
    wait_oe(0, 200, n);
    for (int k = 0; k < 6; k++) begin
      kick = 1;
      step(1);
      kick = 0;
      step(60);
      check(reset_oe_o, 0);
    end
    bad = 1;
    kick = 1;
    step(1);
    kick = 0;
    wait_oe(1, 200, n);
    check(n < 80, 1);
    bad = 0;
    $display("watchdog test done");
  endtask : t_wdog
  task automatic t_lock;
    // Pin high with the lock bit clear, so this write is still taken.
    wp_i = 1;
    step(40);
    wr(LK, 0);
    check(ctrl_o, LK);
    wr(OFF, 1);
    check(ctrl_o, LK);
    wp_i = 0;
    step(40);
    wr(OFF, 0);
    wr(LK, 0);
    $display("lock test done");
  endtask : t_lock
  initial begin
    repeat (4) @(posedge link_clk_i);
    #1 link_rst_i = 0;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    t_power;
    wr(OFF, 0);
    t_supply;
    t_wdog;
    t_lock;
    t_power;
    step(300);
    check(ctrl_o, LK);
    final_report;
  end
endmodule : testbench
